/* bench/transaction_handshake_responder_bench.sv */
// Bench joining host end and function end across the link
`include "trh_cfg.svh"
module transaction_handshake_responder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import trh_pkg::*;
  `define CHK(a, b) begin \
    checked++; \
    if ((a) !== (b)) begin \
      error_cnt++; \
      $display("BAD %0t got %h want %h", $time, a, b); \
    end \
  end
  logic aclk = 0, aresetn = 0, tx_avail = 0, tx_ep = 0, tx_corrupt = 0, rx_room = 1;
  logic pstall_set = 0, tx_take, tx_done, rx_vld, rx_setup, rx_ep, pstall;
  logic [1:0] halt_set = 0, halt_clr = 0, halted, bresp, rresp;
  logic [7:0] tx_byte = 0, rx_byte, ib;
  logic [9:0] r; // Expected setup flag, endpoint and byte
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
  logic [31:0] wdata = 0, rdata, st;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  int error_cnt = 0, checked = 0, cyc = 0, dones = 0;
  trh_pid_e exp_q[$], e, g; // Expected function answers
  logic [9:0] rx_q[$]; // Expected setup flag, endpoint and stored byte
  trh_link_if link_inst();
  trh_dev trh_dev_inst (.aclk, .aresetn, .link(link_inst), .tx_avail, .tx_ep, .tx_byte,
    .tx_corrupt, .tx_take, .tx_done, .rx_room, .rx_vld, .rx_byte, .rx_setup, .rx_ep,
    .halt_set, .halt_clr, .pstall_set, .halted, .pstall);
  trh_host trh_host_inst (.aclk, .aresetn, .link(link_inst), .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  trh_props trh_props_inst (.aclk, .aresetn, .h_vld(link_inst.h_vld),
    .h_pid(link_inst.h_pid), .h_ep(link_inst.h_ep), .h_err(link_inst.h_err),
    .h_len(link_inst.h_len), .d_vld(link_inst.d_vld), .d_pid(link_inst.d_pid),
    .d_err(link_inst.d_err), .d_len(link_inst.d_len));
  always #50 aclk = ~aclk;
  // Hang guard, far above the several hundred cycles needed
  always @(posedge aclk) begin
    cyc++;
    dones += int'(tx_done === 1'b1);
    if (cyc == 6000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // Monitor: compare each answer with the oldest note; data toggle checked apart
  always @(negedge aclk) begin
    if (link_inst.d_vld === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : PID_OUT;
      g = link_inst.d_pid == PID_DATA1 ? PID_DATA0 : link_inst.d_pid;
      `CHK(g, e)
    end
    if (rx_vld === 1'b1) begin
      // Setup on endpoint 1 never happens, so the empty-queue value always mismatches
      r = rx_q.size() ? rx_q.pop_front() : 10'h3FF;
      `CHK({rx_setup, rx_ep, rx_byte}, r)
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Write both halves together, release each when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awready === 1'b1;
      tw = pw && wready === 1'b1;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    `CHK(bresp, er)
    @(posedge aclk);
    bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    st = rdata;
    @(posedge aclk);
    rready <= 0;
  endtask
  // One transaction; f holds toggle, corrupt token, stored, answered
  task automatic txn(input trh_kind_e k, input logic ep, input logic [3:0] f,
                     input trh_pid_e p, input logic [2:0] res);
    logic [7:0] b;
    b = 8'($urandom());
    if (f[1]) rx_q.push_back({k == KIND_SETUP, ep, b});
    if (f[0]) exp_q.push_back(p);
    wr(`TRH_CMD_OFS, {14'h0, f[2], f[3], b, 3'h0, ep, 2'h0, k}, 2'h0);
    do rd(`TRH_STAT_OFS); while (st[0] !== 1'b0);
    `CHK(st[3:1], res)
    repeat (18) @(posedge aclk);
  endtask
  // Offer one byte to the hold register
  task automatic offer();
    ib = 8'($urandom());
    @(posedge aclk);
    tx_ep <= 0;
    tx_byte <= ib;
    tx_avail <= 1;
    do @(negedge aclk); while (tx_take !== 1'b1);
    @(posedge aclk);
    tx_avail <= 0;
  endtask
  task automatic pulse(input logic [1:0] hs, input logic [1:0] hc, input logic ps);
    halt_set <= hs;
    halt_clr <= hc;
    pstall_set <= ps;
    @(posedge aclk);
    halt_set <= 2'h0;
    halt_clr <= 2'h0;
    pstall_set <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'hC1573AE0));
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(`TRH_CTRL_OFS);
    `CHK(st, `TRH_CTRL_RST)
    wr(4'hC, 32'h0, 2'h2);
    txn(KIND_OUT, 1'b1, 4'h3, PID_ACK, 3'h1);
    txn(KIND_OUT, 1'b1, 4'h1, PID_ACK, 3'h1);
    rx_room <= 0;
    txn(KIND_OUT, 1'b1, 4'h9, PID_NAK, 3'h2);
    pulse(2'h2, 2'h0, 1'b0);
    txn(KIND_OUT, 1'b1, 4'h9, PID_STALL, 3'h3);
    txn(KIND_IN, 1'b1, 4'h1, PID_STALL, 3'h3);
    `CHK(halted, 2'h2)
    pulse(2'h0, 2'h2, 1'b0);
    rx_room <= 1;
    txn(KIND_IN, 1'b0, 4'h1, PID_NAK, 3'h2);
    offer();
    tx_corrupt <= 1;
    txn(KIND_IN, 1'b0, 4'h1, PID_DATA0, 3'h5);
    tx_corrupt <= 0;
    wr(`TRH_CTRL_OFS, 32'h0, 2'h0);
    txn(KIND_IN, 1'b0, 4'h1, PID_DATA0, 3'h5);
    wr(`TRH_CTRL_OFS, 32'h1, 2'h0);
    txn(KIND_IN, 1'b0, 4'h1, PID_DATA0, 3'h4);
    `CHK(st[15:8], ib)
    `CHK(dones, 1)
    offer();
    txn(KIND_OUT, 1'b1, 4'hC, PID_ACK, 3'h0);
    txn(KIND_IN, 1'b0, 4'h4, PID_ACK, 3'h0);
    txn(KIND_SETUP, 1'b1, 4'h0, PID_ACK, 3'h0);
    pulse(2'h0, 2'h0, 1'b1);
    txn(KIND_IN, 1'b0, 4'h1, PID_STALL, 3'h3);
    rx_room <= 0;
    txn(KIND_SETUP, 1'b0, 4'h3, PID_ACK, 3'h1);
    `CHK(pstall, 1'b0)
    rx_room <= 1;
    txn(KIND_OUT, 1'b0, 4'hB, PID_ACK, 3'h1);
    txn(KIND_IN, 1'b0, 4'h1, PID_DATA0, 3'h4);
    `CHK(st[16], 1'b1)
    `CHK(st[15:8], ib)
    `CHK(dones, 2)
    `CHK(exp_q.size(), 0)
    tally_and_finish();
  end
endmodule

/* bench/trh_props.sv */
// Concurrent checks on the packet link between host end and function end
module trh_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic h_vld,
  input wire trh_pkg::trh_pid_e h_pid,
  input wire logic [3:0] h_ep,
  input wire logic h_err,
  input wire logic [2:0] h_len,
  input wire logic d_vld,
  input wire trh_pkg::trh_pid_e d_pid,
  input wire logic d_err,
  input wire logic [2:0] d_len
);
  import trh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Clean token to a served endpoint
  wire tok_ok = h_vld && !h_err && h_len == 3'h3 && h_ep < 4'h2;
  a_in_answer_next: assert property (tok_ok && h_pid == PID_IN
    |=> d_vld && d_pid != PID_ACK)
    else $error("IN token not answered next cycle");
  a_bad_tok_quiet: assert property (h_vld && h_err |=> !d_vld [*3])
    else $error("answer after corrupted token");
  a_setup_ack: assert property (tok_ok && h_pid == PID_SETUP && h_ep == 4'h0
    ##1 h_vld |=> d_vld && d_pid == PID_ACK)
    else $error("SETUP data not acknowledged");
  a_setup_ep_quiet: assert property (tok_ok && h_pid == PID_SETUP && h_ep == 4'h1
    |=> !d_vld [*3])
    else $error("SETUP to plain endpoint answered");
  a_out_answer: assert property (tok_ok && h_pid == PID_OUT ##1 h_vld && !h_err
    |=> d_vld && d_pid inside {PID_ACK, PID_NAK, PID_STALL})
    else $error("OUT data without handshake");
  a_hs_one_byte: assert property (d_vld && d_pid inside {PID_ACK, PID_NAK, PID_STALL}
    |-> d_len == 3'h1 && !d_err)
    else $error("handshake length wrong");
  a_host_ack_only: assert property (h_vld && h_len == 3'h1
    |-> h_pid == PID_ACK && !h_err)
    else $error("host sent other handshake");
  a_bad_data_drop: assert property (d_vld && d_err |=> !h_vld [*2])
    else $error("host answered corrupted data");
  a_answer_asked: assert property (d_vld |-> $past(h_vld))
    else $error("unsolicited function packet");
endmodule

/* rtl/trh_cfg.svh */
// Constants for the transaction handshake responder: sizes, timing, host register map
`ifndef TRH_CFG_SVH
`define TRH_CFG_SVH
// Endpoints served by the function end; endpoint 0 is the control pipe
`define TRH_NUM_EP 2
// Packet lengths in bytes, PID included
`define TRH_HS_LEN 3'h1
`define TRH_TOK_LEN 3'h3
`define TRH_DAT_LEN 3'h4
// Clock period and the longest wait for the far end's packet
`define TRH_CLK_NS 100
`define TRH_WAIT_NS 1600
`define TRH_WAIT_CYC (`TRH_WAIT_NS / `TRH_CLK_NS)
// Host register offsets, byte addresses
`define TRH_CMD_OFS 4'h0
`define TRH_CTRL_OFS 4'h4
`define TRH_STAT_OFS 4'h8
// Command register fields
`define TRH_CMD_KIND_LSB 0
`define TRH_CMD_EP_LSB 4
`define TRH_CMD_DAT_LSB 8
`define TRH_CMD_TOG_BIT 16
`define TRH_CMD_ERR_BIT 17
// Control register field and reset value
`define TRH_CTRL_ROOM_BIT 0
`define TRH_CTRL_RST 32'h0000_0001
// Status register fields
`define TRH_STAT_BUSY_BIT 0
`define TRH_STAT_RES_LSB 1
`define TRH_STAT_DAT_LSB 8
`define TRH_STAT_TOG_BIT 16
// Bus responses
`define TRH_RESP_OKAY 2'h0
`define TRH_RESP_SLVERR 2'h2
`endif

/* rtl/trh_dev.sv */
// Function end: picks the answer to each IN, OUT and SETUP transaction
`include "trh_cfg.svh"
module trh_dev (
  input wire logic aclk,
  input wire logic aresetn,
  trh_link_if.dev link,
  input wire logic tx_avail,
  input wire logic tx_ep,
  input wire logic [7:0] tx_byte,
  input wire logic tx_corrupt,
  output logic tx_take,
  output logic tx_done,
  input wire logic rx_room,
  output logic rx_vld,
  output logic [7:0] rx_byte,
  output logic rx_setup,
  output logic rx_ep,
  input wire logic [`TRH_NUM_EP-1:0] halt_set,
  input wire logic [`TRH_NUM_EP-1:0] halt_clr,
  input wire logic pstall_set,
  output logic [`TRH_NUM_EP-1:0] halted,
  output logic pstall
);
  import trh_pkg::*;

  // Token and data packet classes
  function automatic logic is_tok(input trh_pid_e p);
    return (p == PID_OUT) || (p == PID_IN) || (p == PID_SETUP);
  endfunction
  function automatic logic is_dat(input trh_pid_e p);
    return (p == PID_DATA0) || (p == PID_DATA1);
  endfunction
  // Data PID for a toggle value
  function automatic trh_pid_e dat_pid(input logic tog);
    return tog ? PID_DATA1 : PID_DATA0;
  endfunction

  trh_dst_e st_q, st_d; // Transaction state
  logic ep_q, ep_d; // Endpoint of the running transaction
  logic [4:0] cnt_q, cnt_d; // Wait counter in non-idle states
  logic [`TRH_NUM_EP-1:0] halt_q, halt_d; // Functional halt per endpoint
  logic pstall_q, pstall_d; // Protocol stall on the control pipe
  logic [`TRH_NUM_EP-1:0] rxtog_q, rxtog_d; // Expected OUT toggle
  logic [`TRH_NUM_EP-1:0] txtog_q, txtog_d; // Next IN toggle
  logic [7:0] buf_q, buf_d; // Held IN payload
  logic bufv_q, bufv_d; // Held payload valid
  logic bufep_q, bufep_d; // Endpoint owning the held payload
  logic dv_q, dv_d; // Outgoing packet strobe
  trh_pid_e dpid_q, dpid_d; // Outgoing packet identifier
  logic derr_q, derr_d; // Outgoing packet corrupted on purpose
  logic [2:0] dlen_q, dlen_d; // Outgoing packet length
  logic [7:0] ddat_q, ddat_d; // Outgoing payload
  logic done_q, done_d; // Host acknowledged IN payload
  logic rv_q, rv_d; // Received payload strobe
  logic [7:0] rb_q, rb_d; // Received payload byte
  logic rs_q, rs_d; // Received payload came with SETUP
  logic re_q, re_d; // Endpoint of received payload
  logic take_c; // Payload moved into the hold register
  logic idx; // Endpoint addressed by the incoming token
  logic ep_ok; // Token addresses an existing endpoint
  logic stall_c; // Endpoint of the transaction answers STALL

  // Next-state logic for transaction, endpoint state and link output
  always_comb begin
    st_d = st_q;
    ep_d = ep_q;
    cnt_d = cnt_q;
    halt_d = halt_q & ~halt_clr; // Cleared only by host intervention
    pstall_d = pstall_q;
    rxtog_d = rxtog_q;
    txtog_d = txtog_q;
    buf_d = buf_q;
    bufv_d = bufv_q;
    bufep_d = bufep_q;
    dv_d = 1'b0;
    dpid_d = dpid_q;
    derr_d = derr_q;
    dlen_d = dlen_q;
    ddat_d = ddat_q;
    done_d = 1'b0;
    rv_d = 1'b0;
    rb_d = rb_q;
    rs_d = rs_q;
    re_d = re_q;
    take_c = 1'b0;
    idx = link.h_ep[0];
    ep_ok = (link.h_ep < 4'(`TRH_NUM_EP));
    stall_c = halt_q[ep_q] || (!ep_q && pstall_q);
    // Fill the hold register only when empty, so a retry resends the same byte
    if (!bufv_q && tx_avail) begin
      buf_d = tx_byte;
      bufv_d = 1'b1;
      bufep_d = tx_ep;
      take_c = 1'b1;
    end
    // Give up on a missing packet after the wait time
    if (st_q != DS_IDLE) begin
      cnt_d = cnt_q + 5'h01;
      if (cnt_q == 5'(`TRH_WAIT_CYC - 1)) begin
        st_d = DS_IDLE;
      end
    end
    if (link.h_vld && is_tok(link.h_pid)) begin
      // Every token ends the previous transaction
      st_d = DS_IDLE;
      cnt_d = 5'h00;
      ep_d = idx;
      if (link.h_err || (link.h_len != `TRH_TOK_LEN) || !ep_ok) begin
        // Bad token: no answer, and later data is ignored in idle
      end else begin
        unique case (link.h_pid)
          PID_IN: begin
            dv_d = 1'b1;
            derr_d = 1'b0;
            dlen_d = `TRH_HS_LEN;
            if (halt_q[idx] || (!idx && pstall_q)) begin
              dpid_d = PID_STALL;
            end else if (!(bufv_q && (bufep_q == idx))) begin
              dpid_d = PID_NAK;
            end else begin
              // Data instead of handshake, payload stays held
              dpid_d = dat_pid(txtog_q[idx]);
              derr_d = tx_corrupt;
              dlen_d = `TRH_DAT_LEN;
              ddat_d = buf_q;
              st_d = DS_IN_ACK;
            end
          end
          PID_OUT: begin
            st_d = DS_OUT;
          end
          default: begin
            if (!idx) begin
              st_d = DS_SETUP;
              pstall_d = 1'b0; // Protocol stall ends here
            end
            // Other endpoints stay silent
          end
        endcase
      end
    end else if (link.h_vld && is_dat(link.h_pid)) begin
      if (st_q == DS_OUT) begin
        st_d = DS_IDLE;
        // Answer chosen in fixed priority order
        if (link.h_err) begin
          // No handshake on corrupted data
        end else if (stall_c) begin
          dv_d = 1'b1;
          dpid_d = PID_STALL;
          derr_d = 1'b0;
          dlen_d = `TRH_HS_LEN;
        end else if ((link.h_pid == PID_DATA1) != rxtog_q[ep_q]) begin
          dv_d = 1'b1;
          dpid_d = PID_ACK; // Resync, payload dropped
          derr_d = 1'b0;
          dlen_d = `TRH_HS_LEN;
        end else if (!rx_room) begin
          dv_d = 1'b1;
          dpid_d = PID_NAK;
          derr_d = 1'b0;
          dlen_d = `TRH_HS_LEN;
        end else begin
          dv_d = 1'b1;
          dpid_d = PID_ACK;
          derr_d = 1'b0;
          dlen_d = `TRH_HS_LEN;
          rv_d = 1'b1;
          rb_d = link.h_dat;
          rs_d = 1'b0;
          re_d = ep_q;
          rxtog_d[ep_q] = ~rxtog_q[ep_q];
        end
      end else if (st_q == DS_SETUP) begin
        st_d = DS_IDLE;
        if (!link.h_err) begin
          // Always taken and acknowledged, halt or not
          dv_d = 1'b1;
          dpid_d = PID_ACK;
          derr_d = 1'b0;
          dlen_d = `TRH_HS_LEN;
          rv_d = 1'b1;
          rb_d = link.h_dat;
          rs_d = 1'b1;
          re_d = 1'b0;
          // Both directions continue with DATA1 after setup
          rxtog_d[0] = 1'b1;
          txtog_d[0] = 1'b1;
        end
      end
    end else if (link.h_vld && (link.h_pid == PID_ACK) && (st_q == DS_IN_ACK)) begin
      // A handshake longer than one byte is no ACK
      if (!link.h_err && (link.h_len == `TRH_HS_LEN)) begin
        st_d = DS_IDLE;
        bufv_d = 1'b0; // Payload released only now
        txtog_d[ep_q] = ~txtog_q[ep_q];
        done_d = 1'b1;
      end
    end
    // Firmware sets win over clears in the same cycle
    halt_d = halt_d | halt_set;
    if (pstall_set) begin
      pstall_d = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= DS_IDLE;
      ep_q <= 1'b0;
      cnt_q <= 5'h00;
      halt_q <= '0;
      pstall_q <= 1'b0;
      rxtog_q <= '0;
      txtog_q <= '0;
      buf_q <= 8'h00;
      bufv_q <= 1'b0;
      bufep_q <= 1'b0;
      dv_q <= 1'b0;
      dpid_q <= PID_NAK;
      derr_q <= 1'b0;
      dlen_q <= 3'h0;
      ddat_q <= 8'h00;
      done_q <= 1'b0;
      rv_q <= 1'b0;
      rb_q <= 8'h00;
      rs_q <= 1'b0;
      re_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ep_q <= ep_d;
      cnt_q <= cnt_d;
      halt_q <= halt_d;
      pstall_q <= pstall_d;
      rxtog_q <= rxtog_d;
      txtog_q <= txtog_d;
      buf_q <= buf_d;
      bufv_q <= bufv_d;
      bufep_q <= bufep_d;
      dv_q <= dv_d;
      dpid_q <= dpid_d;
      derr_q <= derr_d;
      dlen_q <= dlen_d;
      ddat_q <= ddat_d;
      done_q <= done_d;
      rv_q <= rv_d;
      rb_q <= rb_d;
      rs_q <= rs_d;
      re_q <= re_d;
    end
  end

  // Outputs
  assign link.d_vld = dv_q;
  assign link.d_pid = dpid_q;
  assign link.d_err = derr_q;
  assign link.d_len = dlen_q;
  assign link.d_dat = ddat_q;
  assign tx_take = take_c;
  assign tx_done = done_q;
  assign rx_vld = rv_q;
  assign rx_byte = rb_q;
  assign rx_setup = rs_q;
  assign rx_ep = re_q;
  assign halted = halt_q;
  assign pstall = pstall_q;
endmodule

/* rtl/trh_host.sv */
// Host end: runs one transaction per software command, AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "trh_cfg.svh"
module trh_host (
  input wire logic aclk,
  input wire logic aresetn,
  trh_link_if.host link,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import trh_pkg::*;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  trh_hst_e st_q, st_d; // Transaction state
  logic [4:0] cnt_q, cnt_d; // Wait counter
  trh_kind_e kind_q, kind_d; // Running transaction kind
  logic [31:0] cmd_q, cmd_d; // Last command word
  logic [31:0] ctrl_q, ctrl_d; // Control register
  trh_res_e res_q, res_d; // Outcome
  logic [7:0] idat_q, idat_d; // Last accepted IN byte
  logic itog_q, itog_d; // Toggle of last accepted IN byte
  logic awv_q, awv_d; // Write address held
  logic [3:0] aw_q, aw_d;
  logic wv_q, wv_d; // Write data held
  logic [31:0] w_q, w_d;
  logic [3:0] s_q, s_d;
  logic bv_q, bv_d;
  logic [1:0] br_q, br_d;
  logic rv_q, rv_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0] rr_q, rr_d;
  logic hv_q, hv_d; // Link output registers
  trh_pid_e hpid_q, hpid_d;
  logic [3:0] hep_q, hep_d;
  logic herr_q, herr_d;
  logic [2:0] hlen_q, hlen_d;
  logic [7:0] hdat_q, hdat_d;
  logic [31:0] cw; // Merged command word
  logic [31:0] st_w; // Status word

  // Next-state logic for the bus slave and the transaction engine
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    cmd_d = cmd_q;
    ctrl_d = ctrl_q;
    res_d = res_q;
    idat_d = idat_q;
    itog_d = itog_q;
    awv_d = awv_q;
    aw_d = aw_q;
    wv_d = wv_q;
    w_d = w_q;
    s_d = s_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    hv_d = 1'b0;
    hpid_d = hpid_q;
    hep_d = hep_q;
    herr_d = 1'b0;
    hlen_d = hlen_q;
    hdat_d = hdat_q;
    cw = merge(32'h0000_0000, w_q, s_q);
    st_w = 32'h0000_0000;
    st_w[`TRH_STAT_BUSY_BIT] = (st_q != HS_IDLE);
    st_w[`TRH_STAT_RES_LSB +: 3] = res_q;
    st_w[`TRH_STAT_DAT_LSB +: 8] = idat_q;
    st_w[`TRH_STAT_TOG_BIT] = itog_q;
    // Address and data are taken in either order
    if (awvalid && awready) begin
      awv_d = 1'b1;
      aw_d = awaddr;
    end
    if (wvalid && wready) begin
      wv_d = 1'b1;
      w_d = wdata;
      s_d = wstrb;
    end
    if (bv_q && bready) begin
      bv_d = 1'b0;
    end
    // Write performed once both halves are held
    if (awv_q && wv_q) begin
      awv_d = 1'b0;
      wv_d = 1'b0;
      bv_d = 1'b1;
      br_d = `TRH_RESP_OKAY;
      if (aw_q == `TRH_CTRL_OFS) begin
        ctrl_d = merge(ctrl_q, w_q, s_q);
      end else if (aw_q == `TRH_CMD_OFS) begin
        // A command while busy is dropped; software polls busy first
        if (st_q == HS_IDLE && trh_kind_e'(cw[`TRH_CMD_KIND_LSB +: 2]) != KIND_NONE) begin
          cmd_d = cw;
          kind_d = trh_kind_e'(cw[`TRH_CMD_KIND_LSB +: 2]);
          res_d = RES_NONE;
          hv_d = 1'b1;
          hpid_d = (kind_d == KIND_IN) ? PID_IN : (kind_d == KIND_OUT) ? PID_OUT : PID_SETUP;
          hep_d = cw[`TRH_CMD_EP_LSB +: 4];
          herr_d = cw[`TRH_CMD_ERR_BIT];
          hlen_d = `TRH_TOK_LEN;
          cnt_d = 5'h00;
          st_d = (kind_d == KIND_IN) ? HS_WAIT : HS_DAT;
        end
      end else if (aw_q != `TRH_STAT_OFS) begin
        br_d = `TRH_RESP_SLVERR;
      end
    end
    // Read answered one cycle after the address is taken
    if (rv_q && rready) begin
      rv_d = 1'b0;
    end
    if (arvalid && arready) begin
      rv_d = 1'b1;
      rr_d = `TRH_RESP_OKAY;
      unique case (araddr)
        `TRH_CMD_OFS: rd_d = cmd_q;
        `TRH_CTRL_OFS: rd_d = ctrl_q;
        `TRH_STAT_OFS: rd_d = st_w;
        default: begin
          rd_d = 32'h0000_0000;
          rr_d = `TRH_RESP_SLVERR;
        end
      endcase
    end
    // Transaction engine
    unique case (st_q)
      HS_IDLE: begin
      end
      HS_DAT: begin
        // Data packet right after the OUT or SETUP token
        hv_d = 1'b1;
        hpid_d = (cmd_q[`TRH_CMD_TOG_BIT] && kind_q == KIND_OUT) ? PID_DATA1 : PID_DATA0;
        hdat_d = cmd_q[`TRH_CMD_DAT_LSB +: 8];
        hlen_d = `TRH_DAT_LEN;
        st_d = HS_WAIT;
      end
      HS_WAIT: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == 5'(`TRH_WAIT_CYC - 1)) begin
          st_d = HS_IDLE; // Timeout leaves RES_NONE
        end
        if (link.d_vld) begin
          if (link.d_pid == PID_DATA0 || link.d_pid == PID_DATA1) begin
            if (kind_q == KIND_IN) begin
              st_d = HS_IDLE;
              if (link.d_err || !ctrl_q[`TRH_CTRL_ROOM_BIT]) begin
                res_d = RES_DROP; // Silent drop
              end else begin
                // Only ACK is ever sent by this end
                res_d = RES_DATA;
                idat_d = link.d_dat;
                itog_d = (link.d_pid == PID_DATA1);
                hv_d = 1'b1;
                hpid_d = PID_ACK;
                hlen_d = `TRH_HS_LEN;
              end
            end
          end else if (!link.d_err && link.d_len == `TRH_HS_LEN) begin
            // Handshakes of any other length are ignored
            st_d = HS_IDLE;
            res_d = (link.d_pid == PID_ACK) ? RES_ACK :
                    (link.d_pid == PID_NAK) ? RES_NAK : RES_STALL;
          end
        end
      end
      default: begin
        st_d = HS_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= HS_IDLE;
      cnt_q <= 5'h00;
      kind_q <= KIND_NONE;
      cmd_q <= 32'h0000_0000;
      ctrl_q <= `TRH_CTRL_RST;
      res_q <= RES_NONE;
      idat_q <= 8'h00;
      itog_q <= 1'b0;
      awv_q <= 1'b0;
      aw_q <= 4'h0;
      wv_q <= 1'b0;
      w_q <= 32'h0000_0000;
      s_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= 2'h0;
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'h0;
      hv_q <= 1'b0;
      hpid_q <= PID_ACK;
      hep_q <= 4'h0;
      herr_q <= 1'b0;
      hlen_q <= 3'h0;
      hdat_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
      cmd_q <= cmd_d;
      ctrl_q <= ctrl_d;
      res_q <= res_d;
      idat_q <= idat_d;
      itog_q <= itog_d;
      awv_q <= awv_d;
      aw_q <= aw_d;
      wv_q <= wv_d;
      w_q <= w_d;
      s_q <= s_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      hv_q <= hv_d;
      hpid_q <= hpid_d;
      hep_q <= hep_d;
      herr_q <= herr_d;
      hlen_q <= hlen_d;
      hdat_q <= hdat_d;
    end
  end

  // Outputs; ready terms stall while a half or an answer is pending
  assign awready = !awv_q && !bv_q;
  assign wready = !wv_q && !bv_q;
  assign arready = !rv_q;
  assign bvalid = bv_q;
  assign bresp = br_q;
  assign rvalid = rv_q;
  assign rdata = rd_q;
  assign rresp = rr_q;
  assign link.h_vld = hv_q;
  assign link.h_pid = hpid_q;
  assign link.h_ep = hep_q;
  assign link.h_err = herr_q;
  assign link.h_len = hlen_q;
  assign link.h_dat = hdat_q;
endmodule

/* rtl/trh_link_if.sv */
// Packet-level link between host end and function end
interface trh_link_if;
  import trh_pkg::*;
  logic h_vld; // Host packet strobe, one cycle
  trh_pid_e h_pid; // Host packet identifier
  logic [3:0] h_ep; // Endpoint field of a token
  logic h_err; // Packet arrives corrupted
  logic [2:0] h_len; // Bytes before end of packet
  logic [7:0] h_dat; // Payload byte of a data packet
  logic d_vld; // Function packet strobe, one cycle
  trh_pid_e d_pid; // Function packet identifier
  logic d_err; // Function packet arrives corrupted
  logic [2:0] d_len; // Bytes before end of packet
  logic [7:0] d_dat; // Payload byte of a data packet
  modport dev (
    input h_vld, h_pid, h_ep, h_err, h_len, h_dat,
    output d_vld, d_pid, d_err, d_len, d_dat
  );
  modport host (
    output h_vld, h_pid, h_ep, h_err, h_len, h_dat,
    input d_vld, d_pid, d_err, d_len, d_dat
  );
endinterface

/* rtl/trh_pkg.sv */
// Types shared by both ends of the transaction handshake responder
package trh_pkg;
  // Packet identifiers as carried on the link
  typedef enum logic [3:0] {
    PID_OUT = 4'h1,
    PID_IN = 4'h9,
    PID_SETUP = 4'hD,
    PID_DATA0 = 4'h3,
    PID_DATA1 = 4'hB,
    PID_ACK = 4'h2,
    PID_NAK = 4'hA,
    PID_STALL = 4'hE
  } trh_pid_e;
  // Function end transaction states
  typedef enum logic [1:0] {
    DS_IDLE = 2'h0,
    DS_OUT = 2'h1,
    DS_SETUP = 2'h2,
    DS_IN_ACK = 2'h3
  } trh_dst_e;
  // Host end transaction states
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_DAT = 2'h1,
    HS_WAIT = 2'h2
  } trh_hst_e;
  // Transaction kinds ordered by software
  typedef enum logic [1:0] {
    KIND_OUT = 2'h0,
    KIND_IN = 2'h1,
    KIND_SETUP = 2'h2,
    KIND_NONE = 2'h3
  } trh_kind_e;
  // Outcome of the last host transaction
  typedef enum logic [2:0] {
    RES_NONE = 3'h0,
    RES_ACK = 3'h1,
    RES_NAK = 3'h2,
    RES_STALL = 3'h3,
    RES_DATA = 3'h4,
    RES_DROP = 3'h5
  } trh_res_e;
endpackage
